// >>> cam_chan_end.sv
// requesting channel end: sends request tokens, collects reply tokens
// assumes the bench calls sendTok and idle from one process
`timescale 1ns/1ps
module cam_chan_end
  import cam_pkg::*;
(
  input wire logic clk,
  input wire logic stall,
  output cam_tok_t inTok,
  output logic [31:0] inDest,
  output logic inValid,
  input wire logic inReady,
  input wire cam_tok_t outTok,
  input wire logic [23:0] outDest,
  input wire logic outValid,
  output logic outReady
);
  cam_tok_t rxTok[$];
  logic [23:0] rxDest[$];
  logic [1:0] phase = 2'h0;
  int hung = 0;
  initial begin
    inTok = '0;
    inDest = '0;
    inValid = 1'b0;
    outReady = 1'b1;
  end
  // slow mode takes one reply token in four, so the handler must hold its output
  always @(negedge clk) begin
    phase <= phase + 2'h1;
    outReady <= !stall || phase == 2'h3;
  end
  always @(posedge clk) begin
    if (outValid && outReady) begin
      rxTok.push_back(outTok);
      rxDest.push_back(outDest);
    end
  end
  // token held until taken or for 200 cycles at most; message order is the caller's
  task automatic sendTok(input cam_tok_t t, input logic [31:0] d);
    int n;
    @(negedge clk);
    inTok = t;
    inDest = d;
    inValid = 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!inReady && n < 200);
    if (n == 200) hung++;
  endtask
  // released lines show the inverse of the last token
  task automatic idle();
    @(negedge clk);
    inValid = 1'b0;
    inTok = ~inTok;
    inDest = ~inDest;
  endtask
endmodule

// >>> cam_handler.sv
// configuration access message handler: parses request messages, runs register accesses, sends replies
// assumes the register back end answers each request with one regAck pulse, and that all ports share clk
`timescale 1ns/1ps
module cam_handler
  import cam_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] tileId,
  input wire logic [15:0] nodeId,
  input wire cam_tok_t inTok,
  input wire logic [31:0] inDest,
  input wire logic inValid,
  output logic inReady,
  output cam_tok_t outTok,
  output logic [23:0] outDest,
  output logic outValid,
  input wire logic outReady,
  output cam_req_t regReq,
  output logic regValid,
  input wire logic regAck,
  input wire logic regOk,
  input wire logic [31:0] regRdata
);

  // ==========================================================
  // state and storage
  typedef enum logic [3:0] {
    S_IDLE, S_RID, S_REGN, S_SIZE, S_DATA, S_END, S_SKIP, S_ACC, S_WAIT, S_RHEAD, S_RDATA, S_RTAIL
  } cam_state_t;

  cam_state_t state_r;
  cam_state_t state_nxt;
  cam_tgt_t tgt_r;
  logic isWrite_r;
  logic isPeriph_r;
  logic [7:0] periph_r;
  logic [23:0] rid_r;
  logic [15:0] regNum_r;
  logic [7:0] size_r;
  logic [7:0] cnt_r;
  logic ok_r;
  logic inReady_r;
  cam_tok_t outTok_r;
  logic [23:0] outDest_r;
  logic outValid_r;
  cam_req_t regReq_r;
  logic regValid_r;
  // whole peripheral transfers are buffered so the ack/nack token can lead the reply
  logic [7:0] dataBuf [256];

  // ==========================================================
  // decode
  wire inTake = inValid && inReady_r;
  wire isEnd = inTok.ctrl && (inTok.data == CAM_TOK_END);
  wire cam_tgt_t tgtIn = camDecodeDest(inDest, tileId, nodeId);
  wire cmdWord = (inTok.data == CAM_TOK_WRITE) || (inTok.data == CAM_TOK_READ);
  wire cmdPeriph = (inTok.data == CAM_TOK_PWRITE) || (inTok.data == CAM_TOK_PREAD);
  wire cmdIsWrite = (inTok.data == CAM_TOK_WRITE) || (inTok.data == CAM_TOK_PWRITE);
  wire cmdOk = inTok.ctrl && (((tgtIn == CAM_TGT_TILE || tgtIn == CAM_TGT_NODE) && cmdWord)
               || (tgtIn == CAM_TGT_PERIPH && cmdPeriph));
  wire lastRid = (cnt_r == CAM_RID_LAST);
  wire lastRegn = isPeriph_r ? (cnt_r == 8'h00) : (cnt_r == 8'h01);
  wire [7:0] accCount = isPeriph_r ? size_r : 8'h01;
  wire [7:0] outCount = isPeriph_r ? size_r : CAM_WORD_BYTES;
  wire lastData = isPeriph_r ? (cnt_r == size_r - 8'h01) : (cnt_r == CAM_WORD_LAST);
  wire lastAcc = (cnt_r == accCount - 8'h01);
  wire lastOut = (cnt_r == outCount - 8'h01);
  wire noReply = isWrite_r && (rid_r[7:0] == CAM_NO_REPLY);
  wire cam_state_t replyState = noReply ? S_IDLE : S_RHEAD;
  wire outFree = !outValid_r || outReady;
  wire inReply = (state_r == S_RHEAD) || (state_r == S_RDATA) || (state_r == S_RTAIL);
  wire outLoad = outFree && inReply;
  wire parseNext = (state_nxt == S_IDLE) || (state_nxt == S_RID) || (state_nxt == S_REGN)
                   || (state_nxt == S_SIZE) || (state_nxt == S_DATA) || (state_nxt == S_END)
                   || (state_nxt == S_SKIP);
  wire [31:0] wordBuf = {dataBuf[0], dataBuf[1], dataBuf[2], dataBuf[3]};
  wire [7:0] headTok = ok_r ? CAM_TOK_ACK : CAM_TOK_NACK;
  // a truncated header ends the message with no reply: the reply end may not be known yet
  wire cam_state_t abortState = isEnd ? S_IDLE : S_SKIP;

  // ==========================================================
  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (inTake && cmdOk) begin
          state_nxt = S_RID;
        end else if (inTake && inTok.ctrl && !isEnd) begin
          state_nxt = S_SKIP;
        end
      end
      S_RID: begin
        if (inTake && inTok.ctrl) begin
          state_nxt = abortState;
        end else if (inTake && lastRid) begin
          state_nxt = S_REGN;
        end
      end
      S_REGN: begin
        if (inTake && inTok.ctrl) begin
          state_nxt = abortState;
        end else if (inTake && lastRegn) begin
          state_nxt = isPeriph_r ? S_SIZE : (isWrite_r ? S_DATA : S_END);
        end
      end
      S_SIZE: begin
        if (inTake && inTok.ctrl) begin
          state_nxt = abortState;
        end else if (inTake) begin
          state_nxt = (isWrite_r && inTok.data != 8'h00) ? S_DATA : S_END;
        end
      end
      S_DATA: begin
        if (inTake && inTok.ctrl) begin
          state_nxt = abortState;
        end else if (inTake && lastData) begin
          state_nxt = S_END;
        end
      end
      S_END: begin
        if (inTake && isEnd) begin
          state_nxt = (accCount == 8'h00) ? replyState : S_ACC;
        end else if (inTake) begin
          state_nxt = S_SKIP;
        end
      end
      S_SKIP: begin
        if (inTake && isEnd) begin
          state_nxt = S_IDLE;
        end
      end
      S_ACC: begin
        state_nxt = S_WAIT;
      end
      S_WAIT: begin
        if (regAck && (!regOk || lastAcc)) begin
          state_nxt = replyState;
        end else if (regAck) begin
          state_nxt = S_ACC;
        end
      end
      S_RHEAD: begin
        if (outFree) begin
          state_nxt = (ok_r && !isWrite_r && outCount != 8'h00) ? S_RDATA : S_RTAIL;
        end
      end
      S_RDATA: begin
        if (outFree && lastOut) begin
          state_nxt = S_RTAIL;
        end
      end
      S_RTAIL: begin
        if (outFree) begin
          state_nxt = S_IDLE;
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  // ==========================================================
  // message fields
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= S_IDLE;
      inReady_r <= 1'b0;
      tgt_r <= CAM_TGT_NONE;
      isWrite_r <= 1'b0;
      isPeriph_r <= 1'b0;
      periph_r <= 8'h00;
      rid_r <= 24'h000000;
      regNum_r <= 16'h0000;
      size_r <= 8'h00;
      ok_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      inReady_r <= parseNext;
      if (state_r == S_IDLE && inTake && cmdOk) begin
        tgt_r <= tgtIn;
        isWrite_r <= cmdIsWrite;
        isPeriph_r <= cmdPeriph;
        periph_r <= inDest[15:8];
        regNum_r <= 16'h0000;
        size_r <= 8'h00;
        ok_r <= 1'b1;
      end
      if (inTake && !inTok.ctrl && state_r == S_RID) begin
        rid_r <= {rid_r[15:0], inTok.data};
      end
      if (inTake && !inTok.ctrl && state_r == S_REGN) begin
        regNum_r <= {regNum_r[7:0], inTok.data};
      end
      if (inTake && !inTok.ctrl && state_r == S_SIZE) begin
        size_r <= inTok.data;
      end
      if (state_r == S_WAIT && regAck) begin
        ok_r <= ok_r && regOk;
      end
    end
  end

  // ==========================================================
  // byte counter: header, data, access and reply positions
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 8'h00;
    end else if (state_nxt != state_r && state_r != S_WAIT && state_r != S_ACC) begin
      cnt_r <= 8'h00;
    end else if (state_r == S_WAIT && regAck) begin
      cnt_r <= lastAcc || !regOk ? 8'h00 : cnt_r + 8'h01;
    end else if ((inTake && !inTok.ctrl && state_r != S_IDLE) || (outLoad && state_r == S_RDATA)) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  // ==========================================================
  // data buffer, no reset needed: every byte is written before it reaches a reply token or a write access
  always_ff @(posedge clk) begin
    if (inTake && !inTok.ctrl && state_r == S_DATA) begin
      dataBuf[cnt_r] <= inTok.data;
    end
    if (state_r == S_WAIT && regAck && regOk && !isWrite_r) begin
      if (isPeriph_r) begin
        dataBuf[cnt_r] <= regRdata[7:0];
      end else begin
        dataBuf[0] <= regRdata[31:24];
        dataBuf[1] <= regRdata[23:16];
        dataBuf[2] <= regRdata[15:8];
        dataBuf[3] <= regRdata[7:0];
      end
    end
  end

  // ==========================================================
  // register back end request, one pulse per access
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regValid_r <= 1'b0;
      regReq_r <= '0;
    end else begin
      regValid_r <= (state_r == S_ACC);
      if (state_r == S_ACC) begin
        regReq_r.tgt <= tgt_r;
        regReq_r.periph <= periph_r;
        regReq_r.regNum <= isPeriph_r ? regNum_r + {8'h00, cnt_r} : regNum_r;
        regReq_r.write <= isWrite_r;
        regReq_r.wdata <= isPeriph_r ? {24'h000000, dataBuf[cnt_r]} : wordBuf;
      end
    end
  end

  // ==========================================================
  // reply tokens
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      outValid_r <= 1'b0;
      outTok_r <= '0;
      outDest_r <= 24'h000000;
    end else begin
      if (outLoad) begin
        outValid_r <= 1'b1;
        outDest_r <= rid_r;
      end else if (outReady) begin
        outValid_r <= 1'b0;
      end
      if (outLoad && state_r == S_RHEAD) begin
        outTok_r <= '{ctrl: 1'b1, data: headTok};
      end else if (outLoad && state_r == S_RDATA) begin
        outTok_r <= '{ctrl: 1'b0, data: dataBuf[cnt_r]};
      end else if (outLoad) begin
        outTok_r <= '{ctrl: 1'b1, data: CAM_TOK_END};
      end
    end
  end

  assign inReady = inReady_r;
  assign outTok = outTok_r;
  assign outDest = outDest_r;
  assign outValid = outValid_r;
  assign regReq = regReq_r;
  assign regValid = regValid_r;

endmodule

// >>> cam_handler_props.sv
// port assertions for the configuration access message handler
// assumes one clock domain and an async active-high reset
`timescale 1ns/1ps
module cam_handler_props
  import cam_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] tileId,
  input wire logic [15:0] nodeId,
  input wire cam_tok_t inTok,
  input wire logic [31:0] inDest,
  input wire logic inValid,
  input wire logic inReady,
  input wire cam_tok_t outTok,
  input wire logic [23:0] outDest,
  input wire logic outValid,
  input wire logic outReady,
  input wire cam_req_t regReq,
  input wire logic regValid,
  input wire logic regAck,
  input wire logic regOk,
  input wire logic [31:0] regRdata
);
  // ==========================================================
  // access strobe and reply framing
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence sHead(logic [7:0] t);
    outValid && outTok == {1'b1, t};
  endsequence
  a_reg_pulse: assert property (regValid |=> !regValid)
    else $error("access strobe longer than one cycle");
  a_ack_gap: assert property (regAck |=> !regValid)
    else $error("access issued right after acknowledge");
  // the closing token may still wait in the output register after the input has reopened
  a_busy_quiet: assert property (regValid || (outValid && outTok != {1'b1, CAM_TOK_END}) |-> !inReady)
    else $error("input open while access or reply runs");
  a_out_hold: assert property (outValid && !outReady |=> outValid && $stable(outTok))
    else $error("reply token changed while stalled");
  a_head_first: assert property ($rose(outValid) |-> sHead(CAM_TOK_ACK) or sHead(CAM_TOK_NACK))
    else $error("reply does not open with status token");
  a_fail_head: assert property (regAck && !regOk && !regReq.write |-> ##2 sHead(CAM_TOK_NACK))
    else $error("refused read not answered with failure");
  a_read_head: assert property (regAck && regOk && !regReq.write && regReq.tgt != CAM_TGT_PERIPH
    |-> ##2 sHead(CAM_TOK_ACK))
    else $error("word read not answered with success");
  a_tail_done: assert property (outValid && outReady && outTok == {1'b1, CAM_TOK_END}
    |=> !outValid && inReady)
    else $error("reply not closed after end token");
  a_dest_stable: assert property (outValid && $past(outValid) |-> $stable(outDest))
    else $error("reply destination changed in message");
endmodule

bind cam_handler cam_handler_props u_props (.clk, .rst, .tileId, .nodeId, .inTok, .inDest, .inValid,
  .inReady, .outTok, .outDest, .outValid, .outReady, .regReq, .regValid, .regAck, .regOk, .regRdata);

// >>> cam_pkg.sv
// constants, token encodings and carrier types for the configuration access message handler
// assumes the interconnect presents one token per cycle with a valid/ready handshake on the core clock
// Behaviour
// - tile endpoint: tile id above fixed code
// - node endpoint: node id above fixed code
// - peripheral endpoint: node id, peripheral id, 02
// - word write: 192, reply id, reg, data, 1
// - word read: 193, reply id, reg, 1
// - write reply: 3,1 success or 4,1 failure
// - word read reply: 3, value, 1 or 4,1
// - peripheral write: 36, id, reg, size, bytes, 1
// - peripheral read 37; reply 3, bytes, 1
// - reply id low byte all ones suppresses the reply to a write; reads are still answered
// - multi-byte fields travel most significant byte first
package cam_pkg;

  // ==========================================================
  // token values
  localparam logic [7:0] CAM_TOK_WRITE = 8'hC0;
  localparam logic [7:0] CAM_TOK_READ = 8'hC1;
  localparam logic [7:0] CAM_TOK_PWRITE = 8'h24;
  localparam logic [7:0] CAM_TOK_PREAD = 8'h25;
  localparam logic [7:0] CAM_TOK_ACK = 8'h03;
  localparam logic [7:0] CAM_TOK_NACK = 8'h04;
  localparam logic [7:0] CAM_TOK_END = 8'h01;

  // ==========================================================
  // endpoint codes and field counts
  localparam logic [15:0] CAM_EP_TILE = 16'hC20C;
  localparam logic [15:0] CAM_EP_NODE = 16'hC30C;
  localparam logic [7:0] CAM_EP_PERIPH = 8'h02;
  localparam logic [7:0] CAM_NO_REPLY = 8'hFF;
  localparam logic [7:0] CAM_RID_LAST = 8'h02;
  localparam logic [7:0] CAM_WORD_LAST = 8'h03;
  localparam logic [7:0] CAM_WORD_BYTES = 8'h04;

  // ==========================================================
  // carriers
  typedef enum logic [1:0] {CAM_TGT_NONE, CAM_TGT_TILE, CAM_TGT_NODE, CAM_TGT_PERIPH} cam_tgt_t;

  typedef struct packed {
    logic ctrl;
    logic [7:0] data;
  } cam_tok_t;

  typedef struct packed {
    cam_tgt_t tgt;
    logic [7:0] periph;
    logic [15:0] regNum;
    logic write;
    logic [31:0] wdata;
  } cam_req_t;

  function automatic cam_tgt_t camDecodeDest(input logic [31:0] dest, input logic [15:0] tileId,
                                             input logic [15:0] nodeId);
    cam_tgt_t t;
    t = CAM_TGT_NONE;
    if (dest == {tileId, CAM_EP_TILE}) begin
      t = CAM_TGT_TILE;
    end else if (dest == {nodeId, CAM_EP_NODE}) begin
      t = CAM_TGT_NODE;
    end else if (dest[31:16] == nodeId && dest[7:0] == CAM_EP_PERIPH) begin
      t = CAM_TGT_PERIPH;
    end
    return t;
  endfunction

endpackage

// >>> config_access_message_handler_tb.sv
// self-checking bench for the configuration access message handler
// assumes cam_chan_end as requester; the register back end is modelled here
`timescale 1ns/1ps
module config_access_message_handler_tb;
  import cam_pkg::*;
  logic clk = 1'b0, rst = 1'b1, stall = 1'b0;
  logic [15:0] tileId = 16'h0005, nodeId = 16'h8001;
  logic regAck = 1'b0, regOk = 1'b0, regValid, inValid, inReady, outValid, outReady;
  logic [31:0] regRdata = 32'h0, inDest;
  logic [23:0] outDest;
  cam_tok_t inTok, outTok;
  cam_req_t regReq, lastReq;
  logic [31:0] mem[16];
  int badCount = 0, samplesChecked = 0;
  int accesses = 0;
  cam_tok_t none[$];
  logic [7:0] noBytes[$];
  always #2 clk = ~clk;
  cam_handler u_cam_handler (.clk, .rst, .tileId, .nodeId, .inTok, .inDest, .inValid, .inReady, .outTok,
    .outDest, .outValid, .outReady, .regReq, .regValid, .regAck, .regOk, .regRdata);
  cam_chan_end u_cam_chan_end (.clk, .stall, .inTok, .inDest, .inValid, .inReady, .outTok, .outDest,
    .outValid, .outReady);
  // ==========================================================
  // register back end: answers two cycles late; numbers above 0x000F are missing
  always @(posedge clk) begin
    if (regValid) begin
      accesses++;
      lastReq = regReq;
      repeat (2) @(negedge clk);
      regAck = 1'b1;
      regOk = regReq.regNum < 16'h0010;
      regRdata = mem[regReq.regNum[3:0]];
      if (regOk && regReq.write) mem[regReq.regNum[3:0]] = regReq.wdata;
      @(negedge clk);
      regAck = 1'b0;
    end
  end
  // ==========================================================
  // shared tasks
  function automatic cam_tok_t ctl(input logic [7:0] v);
    return {1'b1, v};
  endfunction
  function automatic cam_tok_t dat(input logic [7:0] v);
    return {1'b0, v};
  endfunction
  task automatic endSim();
    $display("checks %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic msg(input logic [31:0] dest, input logic [7:0] cmd, input logic [23:0] rid,
                     input logic [7:0] b[$]);
    u_cam_chan_end.sendTok(ctl(cmd), dest);
    for (int i = 2; i >= 0; i--) u_cam_chan_end.sendTok(dat(rid[8*i+:8]), dest);
    foreach (b[i]) u_cam_chan_end.sendTok(dat(b[i]), dest);
    u_cam_chan_end.sendTok(ctl(CAM_TOK_END), dest);
    u_cam_chan_end.idle();
  endtask
  task automatic expectReply(input logic [23:0] rid, input cam_tok_t e[$]);
    int n;
    n = 0;
    while (u_cam_chan_end.rxTok.size() < e.size() && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n == 400) begin
      badCount++;
      endSim();
    end
    repeat (12) @(posedge clk);
    check("reply length", e.size(), u_cam_chan_end.rxTok.size());
    foreach (e[i]) begin
      check("reply token", {23'h0, e[i]}, {23'h0, u_cam_chan_end.rxTok[i]});
      check("reply dest", {8'h0, rid}, {8'h0, u_cam_chan_end.rxDest[i]});
    end
    u_cam_chan_end.rxTok.delete();
    u_cam_chan_end.rxDest.delete();
  endtask
  // ==========================================================
  // scenarios
  task automatic testWord();
    msg({tileId, CAM_EP_TILE}, CAM_TOK_WRITE, 24'h8001A3, '{8'h00, 8'h05, 8'hDE, 8'hAD, 8'hBE, 8'hEF});
    expectReply(24'h8001A3, '{ctl(CAM_TOK_ACK), ctl(CAM_TOK_END)});
    check("write target", {30'h0, CAM_TGT_TILE}, {30'h0, lastReq.tgt});
    check("write data", 32'hDEADBEEF, lastReq.wdata);
    check("write flag", 32'h1, {31'h0, lastReq.write});
    stall = 1'b1;
    msg({nodeId, CAM_EP_NODE}, CAM_TOK_READ, 24'h800122, '{8'h00, 8'h05});
    expectReply(24'h800122, '{ctl(CAM_TOK_ACK), dat(8'hDE), dat(8'hAD), dat(8'hBE), dat(8'hEF),
      ctl(CAM_TOK_END)});
    stall = 1'b0;
    check("read target", {30'h0, CAM_TGT_NODE}, {30'h0, lastReq.tgt});
    $display("test word access done");
  endtask
  task automatic testRefused();
    msg({tileId, CAM_EP_TILE}, CAM_TOK_WRITE, 24'h800130, '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01});
    expectReply(24'h800130, '{ctl(CAM_TOK_NACK), ctl(CAM_TOK_END)});
    msg({nodeId, CAM_EP_NODE}, CAM_TOK_READ, 24'h800131, '{8'h00, 8'h20});
    expectReply(24'h800131, '{ctl(CAM_TOK_NACK), ctl(CAM_TOK_END)});
    msg({tileId, 16'hC20D}, CAM_TOK_READ, 24'h800132, '{8'h00, 8'h05});
    expectReply(24'h800132, none);
    $display("test refused access done");
  endtask
  task automatic testSilent();
    msg({tileId, CAM_EP_TILE}, CAM_TOK_WRITE, 24'h8001FF, '{8'h00, 8'h06, 8'h12, 8'h34, 8'h56, 8'h78});
    expectReply(24'h8001FF, none);
    check("silent write data", 32'h12345678, mem[6]);
    $display("test silent write done");
  endtask
  task automatic testPeriph();
    msg({nodeId, 8'h07, CAM_EP_PERIPH}, CAM_TOK_PWRITE, 24'h800140, '{8'h03, 8'h02, 8'h5A, 8'hC3});
    expectReply(24'h800140, '{ctl(CAM_TOK_ACK), ctl(CAM_TOK_END)});
    check("periph id", 32'h7, {24'h0, lastReq.periph});
    check("periph last reg", 32'h4, {16'h0, lastReq.regNum});
    msg({nodeId, 8'h07, CAM_EP_PERIPH}, CAM_TOK_PREAD, 24'h800141, '{8'h03, 8'h02});
    expectReply(24'h800141, '{ctl(CAM_TOK_ACK), dat(8'h5A), dat(8'hC3), ctl(CAM_TOK_END)});
    $display("test peripheral access done");
  endtask
  // malformed or mismatched messages are dropped silently and start no access; a zero-size peripheral write starts no access but is acknowledged
  task automatic testMalformed();
    int a;
    a = accesses;
    msg({tileId, CAM_EP_TILE}, CAM_TOK_PREAD, 24'h800150, '{8'h03, 8'h01});
    expectReply(24'h800150, none);
    msg({16'h0006, CAM_EP_TILE}, CAM_TOK_READ, 24'h800151, '{8'h00, 8'h05});
    expectReply(24'h800151, none);
    msg({nodeId, CAM_EP_NODE}, CAM_TOK_WRITE, 24'h800152, noBytes);
    expectReply(24'h800152, none);
    msg({nodeId, CAM_EP_NODE}, CAM_TOK_READ, 24'h800153, '{8'h00, 8'h05, 8'h77});
    expectReply(24'h800153, none);
    msg({nodeId, 8'h07, CAM_EP_PERIPH}, CAM_TOK_PWRITE, 24'h800154, '{8'h03, 8'h00});
    expectReply(24'h800154, '{ctl(CAM_TOK_ACK), ctl(CAM_TOK_END)});
    check("access count", a, accesses);
    msg({nodeId, CAM_EP_NODE}, CAM_TOK_READ, 24'h8001FF, '{8'h00, 8'h05});
    expectReply(24'h8001FF, '{ctl(CAM_TOK_ACK), dat(8'hDE), dat(8'hAD), dat(8'hBE), dat(8'hEF),
      ctl(CAM_TOK_END)});
    $display("test malformed messages done");
  endtask
  initial begin
    foreach (mem[i]) mem[i] = 32'h0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    testWord();
    testRefused();
    testSilent();
    testPeriph();
    testMalformed();
    check("requester stuck", 32'h0, u_cam_chan_end.hung);
    endSim();
  end
endmodule
